// ===== logic/afss_top.sv
// Converter digital side: result FIFO, status/control register, sequencer
//
// What this block does
// - Threshold flag low at count match, end-conversion
// - Threshold field indexes highest valid location
// - Threshold field reads back, top bit MSB
// - Disable bit set turns flag off
// - Full FIFO with no same-cycle pop drops result, sets overrun
// - Writing overrun bit performs full reset
// - Reset loads mid-scale words, clears register
// - Range error when any held word marked
// - Gate bit zero: bus off during busy
// - Empty flag; empty suppresses shift
// - Head marker reported as head range bit
// - Count is highest valid index
// - Select high reaches register, low FIFO
// - Register read moves no FIFO data
// - Eight thirteen-bit FIFO words
// - Result loaded above top, pointer increments
// - Reads from location 0, then shift down
// - Trial period is clock divided by four
// - Twelve decisions plus range decision
// - Thirteen trials plus one load cycle
// - Host access defers decision one cycle
// - Deferral repeats while access persists
// - First decision four edges after start
`timescale 1ns/1ps
module afss_top (
  input  wire logic                        i_sys_clk,            // System clock, 50 MHz
  input  wire logic                        i_rst,                // Async reset, active high
  input  wire logic                        i_convert_start_n,    // Conversion start, rise
  input  wire logic                        i_chip_select_n,      // Chip select, active low
  input  wire logic                        i_read_strobe_n,      // Read strobe, active low
  input  wire logic                        i_write_strobe_n,     // Write strobe, active low
  input  wire logic                        i_register_select,    // 1 register, 0 FIFO
  input  wire logic [afss_pkg::DATA_W-1:0] i_data,               // Data bus in
  input  wire logic                        i_comparator,         // Comparator decision
  output logic      [afss_pkg::DATA_W-1:0] o_data,               // Data bus out
  output logic                             o_data_oe,            // Data bus enable
  output logic                             o_fifo_threshold_flag_n, // Threshold pin
  output logic                             o_busy_n              // Converting, low
);
  // ----------------------------------------------------------------------
  // Host strobe decode
  // ----------------------------------------------------------------------
  logic start_d;
  logic rd_d;
  logic soft_clr;

  wire cs      = !i_chip_select_n;
  wire rd      = cs && !i_read_strobe_n;
  wire wr      = cs && !i_write_strobe_n;
  wire access  = rd || wr;
  wire reg_wr  = wr && i_register_select;
  wire rd_end  = rd_d && !rd;
  wire start   = !start_d && i_convert_start_n;

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  logic [afss_pkg::PTR_W-1:0] thr;
  logic                       thr_dis;
  logic                       out_gate;
  logic                       overrun;
  logic                       flag_n;
  logic                       fifo_sel_d;

  // Soft reset pulse from overrun position write
  wire next_soft_clr = reg_wr && i_data[afss_pkg::BIT_OVR];

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  logic [afss_pkg::WORD_W-1:0] head;
  logic [3:0]                  level;
  logic                        any_oor;
  logic                        ovr_evt;
  logic [afss_pkg::WORD_W-1:0] result;
  logic                        done;
  logic                        busy;

  // FIFO read completes when a FIFO read strobe ends
  wire pop = rd_end && fifo_sel_d;

  afss_fifo #(
    .DEPTH  (afss_pkg::DEPTH),
    .WORD_W (afss_pkg::WORD_W)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clr     (soft_clr),
    .i_push    (done),
    .i_word    (result),
    .i_pop     (pop),
    .o_head    (head),
    .o_level   (level),
    .o_any_oor (any_oor),
    .o_overrun (ovr_evt)
  );

  afss_seq u_seq (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clr     (soft_clr),
    .i_start   (start),
    .i_access  (access),
    .i_cmp     (i_comparator),
    .o_word    (result),
    .o_done    (done),
    .o_busy    (busy)
  );

  // ----------------------------------------------------------------------
  // Status decode
  // ----------------------------------------------------------------------
  wire       empty    = (level == 4'h0);
  wire [2:0] count    = empty ? 3'h0 : 3'(level - 4'h1);
  // Level after this cycle's push lands, for end-of-conversion compare
  wire [3:0] level_nx = level + {3'h0, done && !ovr_evt};
  wire       match    = (level_nx == ({1'b0, thr} + 4'h1));
  wire       next_flag_n = thr_dis ? 1'b1 : !match;

  wire [afss_pkg::REG_W-1:0] status = {
    flag_n,
    thr,
    thr_dis,
    overrun,
    any_oor,
    empty,
    head[afss_pkg::OOR_BIT],
    count
  };

  // Read data select: register or FIFO head
  wire [afss_pkg::DATA_W-1:0] next_data =
    i_register_select ? status : head[afss_pkg::DATA_W-1:0];
  // Drivers held off during busy unless gate bit set
  wire next_oe = rd && !(busy && !out_gate);

  // ----------------------------------------------------------------------
  // Strobe history and soft reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      start_d    <= 1'b1;
      rd_d       <= 1'b0;
      fifo_sel_d <= 1'b0;
      soft_clr   <= 1'b0;
    end else begin
      start_d    <= i_convert_start_n;
      rd_d       <= rd;
      fifo_sel_d <= rd && !i_register_select;
      soft_clr   <= next_soft_clr;
    end
  end

  // ----------------------------------------------------------------------
  // Control fields; read-only positions not stored
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      thr      <= afss_pkg::RESET_THR;
      thr_dis  <= 1'b0;
      out_gate <= 1'b0;
    end else if (soft_clr) begin
      thr      <= afss_pkg::RESET_THR;
      thr_dis  <= 1'b0;
      out_gate <= 1'b0;
    end else if (reg_wr && !next_soft_clr) begin
      thr      <= i_data[afss_pkg::BIT_THR_HI:afss_pkg::BIT_THR_LO];
      thr_dis  <= i_data[afss_pkg::BIT_THRDIS];
      out_gate <= i_data[afss_pkg::BIT_RANGE];
    end
  end

  // ----------------------------------------------------------------------
  // Overrun sticky and threshold flag
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun <= 1'b0;
      flag_n  <= 1'b1;
    end else if (soft_clr) begin
      overrun <= 1'b0;
      flag_n  <= 1'b1;
    end else begin
      if (ovr_evt) overrun <= 1'b1;
      if (thr_dis) flag_n <= 1'b1;
      else if (done) flag_n <= next_flag_n;
    end
  end

  // ----------------------------------------------------------------------
  // Registered pins
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data                  <= '0;
      o_data_oe               <= 1'b0;
      o_fifo_threshold_flag_n <= 1'b1;
      o_busy_n                <= 1'b1;
    end else begin
      o_data                  <= next_data;
      o_data_oe               <= next_oe;
      o_fifo_threshold_flag_n <= thr_dis ? 1'b1 : flag_n;
      o_busy_n                <= !busy;
    end
  end
endmodule : afss_top

// ===== logic/afss_pkg.sv
// Shared constants for the converter FIFO, status/control and sequencer
package afss_pkg;
  // ----------------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------------
  localparam int DATA_W     = 12;
  localparam int WORD_W     = 13;
  localparam int DEPTH      = 8;
  localparam int PTR_W      = 3;
  localparam int REG_W      = 12;

  // ----------------------------------------------------------------------
  // Status/control field positions
  // ----------------------------------------------------------------------
  localparam int BIT_FLAG    = 11;
  localparam int BIT_THR_HI  = 10;
  localparam int BIT_THR_LO  = 8;
  localparam int BIT_THRDIS  = 7;
  localparam int BIT_OVR     = 6;
  localparam int BIT_RANGE   = 5;
  localparam int BIT_EMPTY   = 4;
  localparam int BIT_HEADOOR = 3;
  localparam int BIT_CNT_HI  = 2;
  localparam int BIT_CNT_LO  = 0;
  localparam int OOR_BIT     = 12;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [WORD_W-1:0] RESET_WORD = 13'h0800;
  localparam logic [PTR_W-1:0]  RESET_THR  = 3'h0;

  // ----------------------------------------------------------------------
  // Sequencer timing
  // ----------------------------------------------------------------------
  localparam int TRIAL_DIV     = 4;
  localparam int N_TRIALS      = 13;
  localparam int FIRST_TRIAL   = 4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_DLY_NS = 25;
  localparam int STROBE_CYC    = (STROBE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIAL_CNT_W   = 4;

  // Sequencer states, Gray along the conversion path
  typedef enum logic [1:0] {
    AFSS_IDLE  = 2'b00,
    AFSS_START = 2'b01,
    AFSS_TRIAL = 2'b11,
    AFSS_LOAD  = 2'b10
  } afss_seq_e;
endpackage : afss_pkg

// ===== logic/afss_fifo.sv
// Eight-word shift-down result FIFO with occupancy pointer
`timescale 1ns/1ps
module afss_fifo #(
  parameter int DEPTH  = afss_pkg::DEPTH,
  parameter int WORD_W = afss_pkg::WORD_W
) (
  input  wire logic              i_sys_clk,  // System clock
  input  wire logic              i_rst,      // Async reset
  input  wire logic              i_clr,      // Soft reset
  input  wire logic              i_push,     // Load result
  input  wire logic [WORD_W-1:0] i_word,     // Result word
  input  wire logic              i_pop,      // Read completed
  output logic      [WORD_W-1:0] o_head,     // Location 0
  output logic      [3:0]        o_level,    // Words held
  output logic                   o_any_oor,  // Any held word out of range
  output logic                   o_overrun   // Push dropped, one cycle
);
  logic [WORD_W-1:0] mem [DEPTH];
  logic [3:0]        level;
  logic [DEPTH-1:0]  oor_valid;

  // Pop only when data held; push only when room after pop
  wire do_pop  = i_pop && (level != 4'h0);
  // Last word stays at location 0 once drained
  wire do_shift = do_pop && (level > 4'h1);
  wire full    = (level == 4'(DEPTH));
  wire do_push = i_push && (!full || do_pop);
  wire [3:0] wr_idx = do_pop ? level - 4'h1 : level;

  assign o_head    = mem[0];
  assign o_level   = level;
  assign o_overrun = i_push && full && !do_pop;
  assign o_any_oor = |oor_valid;

  // Flags of valid words carrying range marker
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_oor
      assign oor_valid[g] = mem[g][afss_pkg::OOR_BIT] && (4'(g) < level);
    end
  endgenerate

  // Shift-down storage
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < DEPTH; k++) mem[k] <= afss_pkg::RESET_WORD;
      level <= 4'h0;
    end else if (i_clr) begin
      for (int k = 0; k < DEPTH; k++) mem[k] <= afss_pkg::RESET_WORD;
      level <= 4'h0;
    end else begin
      if (do_shift)
        for (int k = 0; k < DEPTH-1; k++) mem[k] <= mem[k+1];
      if (do_push) mem[wr_idx[2:0]] <= i_word;
      level <= level + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule : afss_fifo

// ===== logic/afss_seq.sv
// Bit-trial sequencer with access-deferred comparator decisions
`timescale 1ns/1ps
module afss_seq (
  input  wire logic                       i_sys_clk,    // System clock
  input  wire logic                       i_rst,        // Async reset
  input  wire logic                       i_clr,        // Soft reset
  input  wire logic                       i_start,      // Convert start rise
  input  wire logic                       i_access,     // Host strobe active
  input  wire logic                       i_cmp,        // Comparator result
  output logic      [afss_pkg::WORD_W-1:0] o_word,      // Finished result
  output logic                            o_done,       // Result ready pulse
  output logic                            o_busy        // Converting
);
  afss_pkg::afss_seq_e state;
  logic [1:0]                      div;
  logic [afss_pkg::TRIAL_CNT_W-1:0] trial;
  logic [afss_pkg::DATA_W-1:0]     approximation_register;

  // Decision point: end of each divided period, held off by access
  wire tick   = (div == 2'(afss_pkg::TRIAL_DIV - 1));
  wire decide = tick && !i_access;

  assign o_busy = (state != afss_pkg::AFSS_IDLE);

  // Trial loop: 12 data bits then a range decision
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= afss_pkg::AFSS_IDLE;
      div   <= 2'h0;
      trial <= '0;
      approximation_register   <= '0;
      o_word <= afss_pkg::RESET_WORD;
      o_done <= 1'b0;
    end else if (i_clr) begin
      state <= afss_pkg::AFSS_IDLE;
      div   <= 2'h0;
      trial <= '0;
      approximation_register   <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        afss_pkg::AFSS_IDLE: begin
          div <= 2'h0;
          if (i_start) state <= afss_pkg::AFSS_START;
        end
        afss_pkg::AFSS_START: begin
          trial <= '0;
          div   <= 2'h1;
          state <= afss_pkg::AFSS_TRIAL;
        end
        afss_pkg::AFSS_TRIAL: begin
          if (!tick) div <= div + 2'h1;
          else if (decide) begin
            div   <= 2'h0;
            trial <= trial + 1'b1;
            if (trial < 4'(afss_pkg::DATA_W))
              approximation_register[4'(afss_pkg::DATA_W - 1) - trial] <= i_cmp;
            else begin
              o_word <= {i_cmp, approximation_register};
              state  <= afss_pkg::AFSS_LOAD;
            end
          end
        end
        afss_pkg::AFSS_LOAD: begin
          o_done <= 1'b1;
          state  <= afss_pkg::AFSS_IDLE;
        end
        default: state <= afss_pkg::AFSS_IDLE;
      endcase
    end
  end
endmodule : afss_seq

// ===== dv/afss_top_chk.sv
// Port-level assertions for the converter FIFO block
`timescale 1ns/1ps
module afss_top_chk (
  input wire logic        i_sys_clk,               // Clock
  input wire logic        i_rst,                   // Async reset
  input wire logic        i_convert_start_n,       // Conversion start
  input wire logic        i_chip_select_n,         // Chip select
  input wire logic        i_read_strobe_n,         // Read strobe
  input wire logic        i_write_strobe_n,        // Write strobe
  input wire logic        i_register_select,       // Register select
  input wire logic [11:0] i_data,                  // Write data
  input wire logic        o_data_oe,               // Bus enable
  input wire logic        o_fifo_threshold_flag_n, // Threshold pin
  input wire logic        o_busy_n                 // Busy, low
);
  logic       gate;     // Shadow of output gate bit
  logic       dis;      // Shadow of flag disable bit
  logic [8:0] busy_cyc; // Cycles spent busy
  wire        wr_reg = !i_chip_select_n && !i_write_strobe_n && i_register_select;
  wire        rd_any = !i_chip_select_n && !i_read_strobe_n;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // Shadow controls and busy length
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gate     <= 1'b0;
      dis      <= 1'b0;
      busy_cyc <= 9'h000;
    end else begin
      busy_cyc <= o_busy_n ? 9'h000 : busy_cyc + 9'h001;
      if (wr_reg) begin
        gate <= i_data[5] & ~i_data[6];
        dis  <= i_data[7] & ~i_data[6];
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_start; $rose(i_convert_start_n) && o_busy_n; endsequence
  sequence s_busy; !o_busy_n; endsequence
  property p_start; s_start |-> ##[1:2] s_busy; endproperty
  property p_len; $rose(o_busy_n) |-> busy_cyc >= 9'd52 && busy_cyc < 9'd400; endproperty
  property p_gate; s_busy ##1 (s_busy and (!gate && !$past(gate))) |-> !o_data_oe; endproperty
  property p_oe_on; rd_any && gate |=> o_data_oe; endproperty
  property p_oe_src; o_data_oe |-> $past(rd_any); endproperty
  property p_dis; dis && $past(dis) |-> o_fifo_threshold_flag_n; endproperty
  property p_flag_eoc;
    $fell(o_fifo_threshold_flag_n) |-> !o_busy_n || !$past(o_busy_n) || !$past(o_busy_n, 2);
  endproperty
  property p_reset;
    $fell(i_rst) |-> o_busy_n && o_fifo_threshold_flag_n && !o_data_oe;
  endproperty
  a_start: assert property (p_start) else $error("busy missing after start");
  a_len: assert property (p_len) else $error("conversion length out of range");
  a_gate: assert property (p_gate) else $error("bus enabled while busy");
  a_oe_on: assert property (p_oe_on) else $error("read not answered");
  a_oe_src: assert property (p_oe_src) else $error("bus enabled without read");
  a_dis: assert property (p_dis) else $error("flag active while disabled");
  a_flag_eoc: assert property (p_flag_eoc) else $error("flag moved outside load");
  a_reset: assert property (p_reset) else $error("outputs wrong after reset");
endmodule : afss_top_chk

bind afss_top afss_top_chk u_afss_top_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_convert_start_n(i_convert_start_n),
  .i_chip_select_n(i_chip_select_n), .i_read_strobe_n(i_read_strobe_n),
  .i_write_strobe_n(i_write_strobe_n), .i_register_select(i_register_select),
  .i_data(i_data), .o_data_oe(o_data_oe),
  .o_fifo_threshold_flag_n(o_fifo_threshold_flag_n), .o_busy_n(o_busy_n)
);

// ===== dv/afss_host.sv
// Host processor model on the parallel bus
`timescale 1ns/1ps
module afss_host (
  input  wire logic        i_sys_clk, // Shared clock
  input  wire logic [11:0] i_data,    // Device read data
  output logic             o_cs_n,    // Chip select
  output logic             o_rd_n,    // Read strobe
  output logic             o_wr_n,    // Write strobe
  output logic             o_sel,     // Register select
  output logic [11:0]      o_data,    // Write data
  output logic             o_cv_n     // Convert start
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_sel, o_cv_n} = 5'h1f;
    o_data = 12'h000;
  end
  // Register write, taken at one edge; data inverted once released
  task automatic wr(input logic [11:0] d);
    @(negedge i_sys_clk);
    {o_cs_n, o_wr_n, o_sel} = 3'h1;
    o_data = d;
    @(negedge i_sys_clk);
    {o_cs_n, o_wr_n} = 2'h3;
    o_data = ~d;
  endtask : wr
  // Read held n cycles, then spaced before the next access
  task automatic rd(input logic s, input int n, output logic [11:0] q);
    @(negedge i_sys_clk);
    {o_cs_n, o_rd_n, o_sel} = {2'h0, s};
    repeat (n) @(negedge i_sys_clk);
    q = i_data;
    {o_cs_n, o_rd_n} = 2'h3;
    repeat (3) @(negedge i_sys_clk);
  endtask : rd
  // Convert start pulse, two cycles low
  task automatic cv();
    @(negedge i_sys_clk);
    o_cv_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    o_cv_n = 1'b1;
  endtask : cv
endmodule : afss_host

// ===== dv/afss_top_tb.sv
// Self-checking bench for the converter FIFO block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module afss_top_tb;
  logic        i_sys_clk = 1'b0;           // Clock
  logic        i_rst     = 1'b1;           // Reset
  logic        cmp       = 1'b0;           // Comparator level
  wire  logic  cs_n, rd_n, wr_n, sel, cv_n; // Host strobes
  wire  logic [11:0] din;                  // Host write data
  logic [11:0] o_data, q;                  // Read data
  logic        o_data_oe, flag_n, busy_n;  // Device outputs
  int          fails = 0, compares = 0, len, base;
  always #10 i_sys_clk = ~i_sys_clk;
  afss_host u_afss_host (.i_sys_clk(i_sys_clk), .i_data(o_data), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_sel(sel), .o_data(din), .o_cv_n(cv_n));
  afss_top u_afss_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_convert_start_n(cv_n),
    .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
    .i_register_select(sel), .i_data(din), .i_comparator(cmp), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_fifo_threshold_flag_n(flag_n), .o_busy_n(busy_n));
  // One conversion with a fixed comparator level; returns busy length
  task automatic conv(input logic c, output int n);
    cmp = c;
    u_afss_host.cv();
    repeat (3) @(negedge i_sys_clk);
    `CHK(busy_n, 1'b0)
    n = 3;
    while (busy_n !== 1'b1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask : conv
  // Read a register or FIFO word and compare
  task automatic rchk(input logic s, input logic [11:0] e);
    u_afss_host.rd(s, 2, q);
    `CHK(q, e)
  endtask : rchk
  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Watchdog
  initial begin
    #200000;
    fails++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    rchk(1'b1, 12'h810);
    rchk(1'b0, 12'h800);
    rchk(1'b1, 12'h810);
    $display("test reset done");
    u_afss_host.wr(12'h93f);
    rchk(1'b1, 12'h910);
    conv(1'b1, base);
    `CHK(base inside {[53:62]}, 1'b1)
    rchk(1'b1, 12'h928);
    conv(1'b0, len);
    `CHK(len, base)
    @(negedge i_sys_clk); // Pin follows the flag one edge later
    `CHK(flag_n, 1'b0)
    rchk(1'b1, 12'h129);
    rchk(1'b1, 12'h129);
    $display("test fill done");
    rchk(1'b0, 12'hfff);
    rchk(1'b1, 12'h100);
    rchk(1'b0, 12'h000);
    rchk(1'b1, 12'h110);
    rchk(1'b0, 12'h000);
    rchk(1'b1, 12'h110);
    $display("test drain done");
    u_afss_host.wr(12'h180);
    repeat (2) @(negedge i_sys_clk);
    `CHK(flag_n, 1'b1)
    fork
      conv(1'b0, len);
      begin
        repeat (8) @(negedge i_sys_clk);
        u_afss_host.rd(1'b1, 20, q);
      end
    join
    `CHK(len inside {[base + 17:base + 20]}, 1'b1)
    rchk(1'b1, 12'h980);
    $display("test deferral done");
    repeat (8) conv(1'b0, len);
    rchk(1'b1, 12'h9c7);
    $display("test overrun done");
    u_afss_host.wr(12'h040);
    repeat (4) @(negedge i_sys_clk);
    rchk(1'b1, 12'h810);
    rchk(1'b0, 12'h800);
    $display("test soft reset done");
    close_out();
  end
endmodule : afss_top_tb
